// ==== rtl/mmt_pkg.sv ====
/*
  Constants for the motor mode timer: register offsets, field positions, reset values and prescaler codes.
  Assumes a classic Wishbone slave with 32-bit data; each register takes one aligned word.
*/
package mmt_pkg;

  // ----------------------------------------
  // Register index and byte offsets
  // ----------------------------------------
  localparam logic [15:0] MMT_IDX_CTRL_A = 16'h1FA4;
  localparam logic [15:0] MMT_IDX_CTRL_B = 16'h1FA5;
  localparam logic [15:0] MMT_IDX_CAPTURE = 16'h1FA6;
  localparam logic [15:0] MMT_IDX_MODE_TIMER_COMPARE_ONE = 16'h1FA8;
  localparam logic [15:0] MMT_IDX_MODE_TIMER_COMPARE_TWO = 16'h1FAA;
  localparam logic [15:0] MMT_IDX_MODE_TIMER_COMPARE_THREE = 16'h1FAC;
  localparam logic [15:0] MMT_IDX_IRQ_STATUS = 16'h1FB0;
  localparam logic [15:0] MMT_IDX_IRQ_MASK = 16'h1FB1;
  localparam logic [17:0] MMT_OFS_CTRL_A = {MMT_IDX_CTRL_A, 2'b00};
  localparam logic [17:0] MMT_OFS_CTRL_B = {MMT_IDX_CTRL_B, 2'b00};
  localparam logic [17:0] MMT_OFS_CAPTURE = {MMT_IDX_CAPTURE, 2'b00};
  localparam logic [17:0] MMT_OFS_MODE_TIMER_COMPARE_ONE = {MMT_IDX_MODE_TIMER_COMPARE_ONE, 2'b00};
  localparam logic [17:0] MMT_OFS_MODE_TIMER_COMPARE_TWO = {MMT_IDX_MODE_TIMER_COMPARE_TWO, 2'b00};
  localparam logic [17:0] MMT_OFS_MODE_TIMER_COMPARE_THREE = {MMT_IDX_MODE_TIMER_COMPARE_THREE, 2'b00};
  localparam logic [17:0] MMT_OFS_IRQ_STATUS = {MMT_IDX_IRQ_STATUS, 2'b00};
  localparam logic [17:0] MMT_OFS_IRQ_MASK = {MMT_IDX_IRQ_MASK, 2'b00};

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int MMT_A_CLK_LSB = 5;
  localparam int MMT_A_RST_TMR3 = 4;
  localparam int MMT_A_RST_OVL = 3;
  localparam int MMT_A_RST_SW = 2;
  localparam int MMT_A_RST_POS = 1;
  localparam int MMT_A_ENABLE = 0;
  localparam int MMT_B_DEBUG = 7;
  localparam int MMT_B_OVF = 5;
  localparam int MMT_B_CAP_OVL = 3;
  localparam int MMT_B_CAP_SW = 2;
  localparam int MMT_B_CAP_POS = 1;
  localparam int MMT_IRQ_OVF = 0;
  localparam int MMT_IRQ_CAP = 1;

  // ----------------------------------------
  // Reset values and prescaler codes
  // ----------------------------------------
  localparam logic [7:0] MMT_CTRL_A_RST = 8'h00;
  localparam logic [7:0] MMT_CTRL_B_RST = 8'h00;
  localparam logic [15:0] MMT_WORD_RST = 16'h0000;
  localparam logic [1:0] MMT_IRQ_RST = 2'h0;
  localparam logic [6:0] MMT_PRESC_RST = 7'h00;
  localparam logic [2:0] MMT_CLK_DIV8 = 3'h0;
  localparam logic [2:0] MMT_CLK_DIV16 = 3'h2;
  localparam logic [2:0] MMT_CLK_DIV32 = 3'h4;
  localparam logic [2:0] MMT_CLK_DIV64 = 3'h6;
  localparam logic [2:0] MMT_CLK_DIV128 = 3'h1;
  localparam logic [6:0] MMT_LAST_DIV8 = 7'h07;
  localparam logic [6:0] MMT_LAST_DIV16 = 7'h0F;
  localparam logic [6:0] MMT_LAST_DIV32 = 7'h1F;
  localparam logic [6:0] MMT_LAST_DIV64 = 7'h3F;
  localparam logic [6:0] MMT_LAST_DIV128 = 7'h7F;

endpackage

// ==== rtl/mmt_motor_mode_timer.sv ====
/*
  Motor mode timer: prescaled 16-bit counter with capture, resets, three compare registers,
  debug pin and a Wishbone register slave with sticky interrupt status.
  Assumes event inputs are single-cycle pulses on clk_in; adr_in is the byte address.
*/
`timescale 1ns/10ps
module mmt_motor_mode_timer (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [17:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic position_detect_in,
  input wire logic overload_protect_in,
  input wire logic timer_three_event_in,
  output logic debug_pin_out,
  output logic [15:0] count_out,
  output logic irq_out
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [7:0] ctrl_a_r;
  logic [7:0] ctrl_b_r;
  logic [15:0] count_r;
  logic [15:0] capture_r;
  logic [15:0] mode_timer_compare_one_r;
  logic [15:0] mode_timer_compare_two_r;
  logic [15:0] mode_timer_compare_three_r;
  logic [6:0] presc_r;
  logic ovf_r;
  logic [1:0] irq_stat_r;
  logic [1:0] irq_mask_r;
  logic [31:0] rd_data_r;
  logic ack_r;
  logic debug_r;
  logic irq_r;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire bus_req = wb_cyc_in & wb_stb_in & ~ack_r;
  wire wr_lo = bus_req & wb_we_in & wb_sel_in[0];
  wire wr_hi = bus_req & wb_we_in & wb_sel_in[1];
  wire hit_a = wb_adr_in == mmt_pkg::MMT_OFS_CTRL_A;
  wire hit_b = wb_adr_in == mmt_pkg::MMT_OFS_CTRL_B;
  wire hit_cap = wb_adr_in == mmt_pkg::MMT_OFS_CAPTURE;
  wire hit_c1 = wb_adr_in == mmt_pkg::MMT_OFS_MODE_TIMER_COMPARE_ONE;
  wire hit_c2 = wb_adr_in == mmt_pkg::MMT_OFS_MODE_TIMER_COMPARE_TWO;
  wire hit_c3 = wb_adr_in == mmt_pkg::MMT_OFS_MODE_TIMER_COMPARE_THREE;
  wire hit_st = wb_adr_in == mmt_pkg::MMT_OFS_IRQ_STATUS;
  wire hit_mk = wb_adr_in == mmt_pkg::MMT_OFS_IRQ_MASK;
  wire wr_a = wr_lo & hit_a;
  wire wr_b = wr_lo & hit_b;

  // Strobe bits are write-only and never stored, so they read back as zero.
  wire sw_reset = wr_a & wb_dat_in[mmt_pkg::MMT_A_RST_SW];
  wire sw_capture = wr_b & wb_dat_in[mmt_pkg::MMT_B_CAP_SW];

  // ----------------------------------------
  // Prescaler
  // ----------------------------------------
  wire [2:0] clk_sel = ctrl_a_r[7:mmt_pkg::MMT_A_CLK_LSB];
  wire sel_div8 = clk_sel == mmt_pkg::MMT_CLK_DIV8;
  wire sel_div16 = clk_sel == mmt_pkg::MMT_CLK_DIV16;
  wire sel_div32 = clk_sel == mmt_pkg::MMT_CLK_DIV32;
  wire sel_div64 = clk_sel == mmt_pkg::MMT_CLK_DIV64;
  wire sel_div128 = clk_sel == mmt_pkg::MMT_CLK_DIV128;
  // Reserved codes give no tick at all, so a bad setting freezes the count rather than guessing a rate.
  wire [6:0] presc_last = sel_div8 ? mmt_pkg::MMT_LAST_DIV8 :
                          sel_div16 ? mmt_pkg::MMT_LAST_DIV16 :
                          sel_div32 ? mmt_pkg::MMT_LAST_DIV32 :
                          sel_div64 ? mmt_pkg::MMT_LAST_DIV64 :
                          mmt_pkg::MMT_LAST_DIV128;
  wire code_ok = sel_div8 | sel_div16 | sel_div32 | sel_div64 | sel_div128;
  wire enabled = ctrl_a_r[mmt_pkg::MMT_A_ENABLE];
  wire tick = enabled & code_ok & (presc_r >= presc_last);

  // ----------------------------------------
  // Count reset and capture sources
  // ----------------------------------------
  wire rst_pos = ctrl_a_r[mmt_pkg::MMT_A_RST_POS] & position_detect_in;
  wire rst_ovl = ctrl_a_r[mmt_pkg::MMT_A_RST_OVL] & overload_protect_in;
  wire rst_tmr = ctrl_a_r[mmt_pkg::MMT_A_RST_TMR3] & timer_three_event_in;
  wire count_clear = sw_reset | rst_pos | rst_ovl | rst_tmr;
  wire cap_pos = ctrl_b_r[mmt_pkg::MMT_B_CAP_POS] & position_detect_in;
  wire cap_ovl = ctrl_b_r[mmt_pkg::MMT_B_CAP_OVL] & overload_protect_in;
  wire capture = sw_capture | cap_pos | cap_ovl;
  wire wrap = tick & (count_r == 16'hFFFF) & ~count_clear;

  wire [15:0] count_nxt = count_clear ? mmt_pkg::MMT_WORD_RST :
                          tick ? count_r + 16'h0001 : count_r;
  // Counter reset also restarts the prescaler so the first tick after it is a full period.
  wire [6:0] presc_nxt = (count_clear | ~enabled | tick) ? mmt_pkg::MMT_PRESC_RST : presc_r + 7'h01;

  // ----------------------------------------
  // Interrupt status: set wins over write-one-to-clear
  // ----------------------------------------
  wire [1:0] irq_set = {capture, wrap};
  wire [1:0] irq_clr = (wr_lo & hit_st) ? wb_dat_in[1:0] : 2'h0;
  wire [1:0] irq_stat_nxt = irq_set | (irq_stat_r & ~irq_clr);

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  wire [7:0] ctrl_b_view = {ctrl_b_r[7], 1'b0, ovf_r, 1'b0, ctrl_b_r[3], 1'b0, ctrl_b_r[1], 1'b0};
  wire [31:0] rd_nxt = hit_a ? {24'h000000, ctrl_a_r} :
                       hit_b ? {24'h000000, ctrl_b_view} :
                       hit_cap ? {16'h0000, capture_r} :
                       hit_c1 ? {16'h0000, mode_timer_compare_one_r} :
                       hit_c2 ? {16'h0000, mode_timer_compare_two_r} :
                       hit_c3 ? {16'h0000, mode_timer_compare_three_r} :
                       hit_st ? {30'h00000000, irq_stat_r} :
                       hit_mk ? {30'h00000000, irq_mask_r} : 32'h00000000;

  // ----------------------------------------
  // Wishbone handshake
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ack_r <= 1'b0;
      rd_data_r <= 32'h00000000;
    end else begin
      ack_r <= bus_req;
      rd_data_r <= bus_req ? rd_nxt : 32'h00000000;
    end
  end

  // ----------------------------------------
  // Control and compare registers
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl_a_r <= mmt_pkg::MMT_CTRL_A_RST;
      ctrl_b_r <= mmt_pkg::MMT_CTRL_B_RST;
      irq_mask_r <= mmt_pkg::MMT_IRQ_RST;
    end else begin
      if (wr_a) begin
        ctrl_a_r <= wb_dat_in[7:0] & 8'hFB;
      end
      if (wr_b) begin
        ctrl_b_r <= wb_dat_in[7:0] & 8'h8A;
      end
      if (wr_lo & hit_mk) begin
        irq_mask_r <= wb_dat_in[1:0];
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mode_timer_compare_one_r <= mmt_pkg::MMT_WORD_RST;
      mode_timer_compare_two_r <= mmt_pkg::MMT_WORD_RST;
      mode_timer_compare_three_r <= mmt_pkg::MMT_WORD_RST;
    end else begin
      if (hit_c1 & wr_lo) mode_timer_compare_one_r[7:0] <= wb_dat_in[7:0];
      if (hit_c1 & wr_hi) mode_timer_compare_one_r[15:8] <= wb_dat_in[15:8];
      if (hit_c2 & wr_lo) mode_timer_compare_two_r[7:0] <= wb_dat_in[7:0];
      if (hit_c2 & wr_hi) mode_timer_compare_two_r[15:8] <= wb_dat_in[15:8];
      if (hit_c3 & wr_lo) mode_timer_compare_three_r[7:0] <= wb_dat_in[7:0];
      if (hit_c3 & wr_hi) mode_timer_compare_three_r[15:8] <= wb_dat_in[15:8];
    end
  end

  // ----------------------------------------
  // Counter, capture and overflow
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      count_r <= mmt_pkg::MMT_WORD_RST;
      presc_r <= mmt_pkg::MMT_PRESC_RST;
      capture_r <= mmt_pkg::MMT_WORD_RST;
      ovf_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      presc_r <= presc_nxt;
      if (capture) begin
        capture_r <= count_r;
      end
      if (wrap) begin
        ovf_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Status and outputs
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      irq_stat_r <= mmt_pkg::MMT_IRQ_RST;
      irq_r <= 1'b0;
      debug_r <= 1'b0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      irq_r <= |(irq_stat_nxt & irq_mask_r);
      // The debug signal is the prescaled tick, which shows the selected timer rate on the pin.
      debug_r <= ctrl_b_r[mmt_pkg::MMT_B_DEBUG] & tick;
    end
  end

  assign wb_ack_out = ack_r;
  assign wb_dat_out = rd_data_r;
  assign debug_pin_out = debug_r;
  assign count_out = count_r;
  assign irq_out = irq_r;

endmodule

// ==== sim/mmt_checker.sv ====
/*
  Port checker for the motor mode timer: bus handshake, count stepping and debug pulse timing.
  Assumes it is bound to every timer instance and sees only that instance's ports.
*/
`timescale 1ns/10ps
module mmt_checker (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [17:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  input wire logic debug_pin_out,
  input wire logic [15:0] count_out
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_take; wb_cyc_in && wb_stb_in && !wb_ack_out; endsequence
  sequence s_wr_a; s_take ##0 (wb_we_in && wb_sel_in[0] && wb_adr_in == mmt_pkg::MMT_OFS_CTRL_A); endsequence
  sequence s_step; count_out == $past(count_out) + 16'h1; endsequence
  property p_ack; s_take |=> wb_ack_out; endproperty
  property p_ack_pulse; wb_ack_out |=> !wb_ack_out; endproperty
  property p_dat_idle; !wb_ack_out |-> wb_dat_out == 32'h0; endproperty
  property p_step; !$stable(count_out) |-> count_out == $past(count_out) + 16'h1 || count_out == 16'h0; endproperty
  // The fastest legal divider is eight, so a step is always followed by seven quiet cycles.
  property p_div; s_step |=> ($stable(count_out) || count_out == 16'h0) [*7]; endproperty
  property p_sw_rst; s_wr_a ##0 wb_dat_in[2] |=> count_out == 16'h0; endproperty
  property p_off; s_wr_a ##0 !wb_dat_in[0] |=> ##1 ($stable(count_out) || count_out == 16'h0) [*4]; endproperty
  property p_dbg; debug_pin_out |=> (!debug_pin_out) [*7]; endproperty
  a_ack: assert property (p_ack) else $error("request not acknowledged in one cycle");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held longer than one cycle");
  a_dat_idle: assert property (p_dat_idle) else $error("read data not zero outside ack");
  a_step: assert property (p_step) else $error("count moved by other than one or to zero");
  a_div: assert property (p_div) else $error("count stepped faster than the divider allows");
  a_sw_rst: assert property (p_sw_rst) else $error("software reset did not clear the count");
  a_off: assert property (p_off) else $error("count moved while disabled");
  a_dbg: assert property (p_dbg) else $error("debug pulse too close to the previous one");
endmodule

bind mmt_motor_mode_timer mmt_checker i_chk (.clk_in(clk_in), .rst_b_in(rst_b_in), .wb_cyc_in(wb_cyc_in),
  .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
  .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .debug_pin_out(debug_pin_out), .count_out(count_out));

// ==== sim/mmt_motor_mode_timer_tb.sv ====
/*
  Self-checking bench for the motor mode timer: registers, dividers, captures, resets, interrupt.
  Assumes the checker is bound in and the bench alone drives the bus and the event pulses.
*/
`timescale 1ns/10ps
module mmt_motor_mode_timer_tb;
  logic clk_in, rst_b_in, cyc, stb, we, ack, dbg, irq;
  logic [17:0] adr;
  logic [17:0] ofs [6];
  logic [3:0] sel;
  logic [31:0] dat_w, dat_r, q;
  logic [2:0] ev, c;
  logic [15:0] cnt;
  logic [15:0] v [3];
  int n_errors, checked, cycles, k, p;
  mmt_motor_mode_timer i_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dat_w), .wb_dat_out(dat_r), .wb_ack_out(ack),
    .position_detect_in(ev[0]), .overload_protect_in(ev[1]), .timer_three_event_in(ev[2]),
    .debug_pin_out(dbg), .count_out(cnt), .irq_out(irq));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      conclude();
    end
  end
  task automatic conclude();
    $display("mismatches %0d of %0d checks", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [17:0] a, input logic [31:0] d);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (ack !== 1'b1 && n < 40);
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic rd(input logic [17:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    check(q, e);
  endtask
  task automatic pulse(input int i);
    ev[i] <= 1'b1;
    @(posedge clk_in);
    ev <= 3'h0;
    repeat (2) @(posedge clk_in);
  endtask
  // Waits whole divider periods so the tick count is safe against a one-cycle phase offset.
  task automatic run(input int t);
    wb(1'b1, ofs[0], 32'h1);
    repeat (t * 8) @(posedge clk_in);
    wb(1'b1, ofs[0], 32'h0);
  endtask
  function automatic int div_of(input logic [2:0] code);
    return code == 3'h1 ? 128 : 8 << code[2:1];
  endfunction
  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  initial begin
    {cyc, stb, we, ev, rst_b_in} = 7'h0;
    adr = 18'h0;
    sel = 4'h3;
    dat_w = 32'h0;
    ofs = '{mmt_pkg::MMT_OFS_CTRL_A, mmt_pkg::MMT_OFS_CTRL_B, mmt_pkg::MMT_OFS_CAPTURE,
      mmt_pkg::MMT_OFS_MODE_TIMER_COMPARE_ONE, mmt_pkg::MMT_OFS_MODE_TIMER_COMPARE_TWO, mmt_pkg::MMT_OFS_MODE_TIMER_COMPARE_THREE};
    void'($urandom(32'h53C9));
    repeat (20) @(posedge clk_in);
    rst_b_in <= 1'b1;
    @(posedge clk_in);
    for (int i = 0; i < 6; i++) rd(ofs[i], 32'h0);
    for (int i = 0; i < 3; i++) begin
      v[i] = 16'($urandom);
      wb(1'b1, ofs[i + 3], {16'h0, v[i]});
    end
    for (int i = 0; i < 3; i++) rd(ofs[i + 3], {16'h0, v[i]});
    wb(1'b1, ofs[1], 32'hFF);
    rd(ofs[1], 32'h8A);
    wb(1'b1, ofs[0], 32'hFF);
    rd(ofs[0], 32'hFB);
    repeat (100) @(posedge clk_in);
    check(cnt, 0);
    rd(18'h0, 32'h0);
    wb(1'b1, ofs[1], 32'h80);
    for (int i = 0; i < 5; i++) begin
      c = (i == 4) ? 3'h1 : 3'(2 * i);
      wb(1'b1, ofs[0], {24'h0, c, 5'h05});
      k = 0;
      while (cnt !== 16'h1 && k < 300) begin
        @(posedge clk_in);
        k++;
      end
      k = 0;
      p = 0;
      while (cnt !== 16'h2 && k < 300) begin
        @(posedge clk_in);
        k++;
        p += (dbg === 1'b1);
      end
      check(k, div_of(c));
      check(p, 1);
    end
    wb(1'b1, ofs[1], 32'h0);
    p = 0;
    repeat (300) begin
      @(posedge clk_in);
      p += (dbg === 1'b1);
    end
    check(p, 0);
    wb(1'b1, ofs[0], 32'h04);
    check(cnt, 0);
    k = $urandom_range(6, 2);
    run(k);
    repeat (20) @(posedge clk_in);
    check(cnt, k);
    for (int i = 0; i < 3; i++) pulse(i);
    rd(ofs[2], 32'h0);
    check(cnt, k);
    wb(1'b1, ofs[1], 32'h04);
    rd(ofs[2], k);
    for (int i = 0; i < 2; i++) begin
      p = $urandom_range(6, 2);
      run(p);
      k += p;
      wb(1'b1, ofs[1], i ? 32'h08 : 32'h02);
      pulse(i);
      rd(ofs[2], k);
      check(cnt, k);
    end
    for (int i = 0; i < 3; i++) begin
      run(2);
      wb(1'b1, ofs[0], 32'h1 << (i ? i + 2 : 1));
      pulse(i);
      check(cnt, 0);
    end
    rd(mmt_pkg::MMT_OFS_IRQ_STATUS, 32'h1 << mmt_pkg::MMT_IRQ_CAP);
    check(irq, 0);
    wb(1'b1, mmt_pkg::MMT_OFS_IRQ_MASK, 32'h2);
    repeat (2) @(posedge clk_in);
    check(irq, 1);
    wb(1'b1, mmt_pkg::MMT_OFS_IRQ_STATUS, 32'h2);
    repeat (2) @(posedge clk_in);
    check(irq, 0);
    conclude();
  end
endmodule
